// ==== hdl/hps_pkg.sv ====
package hps_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PRESCALE = 8'ha0;
  localparam logic [7:0] ADDR_ACCUM    = 8'ha1;
  localparam logic [7:0] ADDR_PFGW     = 8'ha2;
  localparam logic [7:0] RST_PRESCALE  = 8'h01;
  localparam logic [7:0] RST_ACCUM     = 8'h00;
  localparam logic [7:0] RST_PFGW      = 8'h00;
  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int RATIO_LSB  = 0;
  localparam int RATIO_W    = 6;
  localparam int ACL_LSB    = 0;
  localparam int ACL_W      = 6;
  localparam int DCG_LSB    = 0;
  localparam int DCG_W      = 3;
  localparam int WEIGHT_BIT = 3;
  localparam int PFY_LSB    = 4;
  localparam int PFUV_LSB   = 6;
  localparam int PF_W       = 2;
  // ---------------------------------------------------------------
  // fine scaler limits
  // ---------------------------------------------------------------
  localparam int              PHASE_INC_W     = 13;
  localparam logic [12:0]     PHASE_INC_MIN   = 13'h012c;
  localparam logic [12:0]     PHASE_INC_MAX   = 13'h1fff;
  localparam int              PHASE_UNITY     = 1024;
  localparam int              PHASE_FRAC_BITS = 6;
  // ---------------------------------------------------------------
  // prefilter normalisation shifts
  // ---------------------------------------------------------------
  localparam int SH_121   = 2;
  localparam int SH_WIDE  = 5;
  localparam int SH_12221 = 3;
  localparam int PF_TAPS  = 7;
  // ---------------------------------------------------------------
  // buffering
  // ---------------------------------------------------------------
  localparam int FIFO_DEPTH   = 16;
  localparam int READY_MARGIN = 4;
  typedef enum logic [1:0] {PF_BYPASS, PF_121, PF_WIDE, PF_12221} hps_pf_e;
  typedef enum logic {LN_IDLE, LN_ACTIVE} hps_line_e;
endpackage : hps_pkg

// ==== hdl/hps_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module hps_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 16
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_valid,
  output logic                            o_ready,
  input  wire logic [W-1:0]               i_data,
  output logic                            o_valid,
  input  wire logic                       i_ready,
  output logic [W-1:0]                    o_data,
  output logic [$clog2(DEPTH+1)-1:0]      o_free
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          ov_q, ov_d;
  logic [W-1:0]  od_q, od_d;
  logic          push, pop;
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    push  = i_valid && (cnt_q != CW'(DEPTH));
    pop   = (cnt_q != '0) && (!ov_q || i_ready);
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    ov_d  = ov_q;
    od_d  = od_q;
    if (push) begin
      mem_d[wr_q] = i_data;
      wr_d        = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      od_d = mem_q[rd_q];
      ov_d = 1'b1;
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
    end else if (i_ready) begin
      ov_d = 1'b0;
    end
    cnt_d = cnt_q + CW'(push) - CW'(pop);
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      ov_q  <= ov_d;
      od_q  <= od_d;
    end
  end
  always_ff @(posedge i_clk) begin
    mem_q <= mem_d;
  end
  assign o_ready = (cnt_q != CW'(DEPTH));
  assign o_valid = ov_q;
  assign o_data  = od_q;
  assign o_free  = CW'(DEPTH) - cnt_q;
endmodule : hps_fifo
`default_nettype wire

// ==== hdl/hps_prefilter.sv ====
`timescale 1ns/1ns
`default_nettype none
module hps_prefilter #(
  parameter int W    = 8,
  parameter bit LUMA = 1'b1
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_valid,
  input  wire logic          i_sol,
  input  wire logic          i_eol,
  input  wire logic [1:0]    i_sel,
  input  wire logic [W-1:0]  i_data,
  output logic               o_valid,
  output logic               o_sol,
  output logic               o_eol,
  output logic [W-1:0]       o_filt,
  output logic [W-1:0]       o_raw
);
  localparam int NT = hps_pkg::PF_TAPS;
  logic [W-1:0] tap_q [NT];
  logic [W-1:0] tap_d [NT];
  logic [W-1:0] filt_q, filt_d, raw_q, raw_d;
  logic         v_q, s_q, e_q;
  logic signed [W+8:0] acc;
  logic signed [W+8:0] shf;
  // ---------------------------------------------------------------
  // kernels
  // ---------------------------------------------------------------
  function automatic logic signed [5:0] coef(input logic [1:0] sel, input int i);
    logic signed [5:0] c;
    c = 6'sd0;
    case (hps_pkg::hps_pf_e'(sel))
      hps_pkg::PF_BYPASS: c = (i == 3) ? 6'sd1 : 6'sd0;
      hps_pkg::PF_121:    c = (i == 3) ? 6'sd2 : ((i == 2 || i == 4) ? 6'sd1 : 6'sd0);
      hps_pkg::PF_12221:  c = (i == 1 || i == 5) ? 6'sd1 : ((i == 0 || i == 6) ? 6'sd0 : 6'sd2);
      hps_pkg::PF_WIDE: begin
        if (LUMA) begin
          case (i)
            0, 6:    c = -6'sd4;
            1, 5:    c = 6'sd4;
            2, 4:    c = 6'sd7;
            default: c = 6'sd18;
          endcase
        end else begin
          case (i)
            1, 5:    c = 6'sd3;
            2, 4:    c = 6'sd8;
            3:       c = 6'sd10;
            default: c = 6'sd0;
          endcase
        end
      end
      default: c = 6'sd0;
    endcase
    return c;
  endfunction : coef
  // ---------------------------------------------------------------
  // window and sum
  // ---------------------------------------------------------------
  always_comb begin
    tap_d  = tap_q;
    filt_d = filt_q;
    raw_d  = raw_q;
    acc    = '0;
    shf    = '0;
    if (i_valid) begin
      for (int i = NT-1; i > 0; i--) begin
        tap_d[i] = i_sol ? i_data : tap_q[i-1];
      end
      tap_d[0] = i_data;
      for (int i = 0; i < NT; i++) begin
        acc = acc + (W+9)'(coef(i_sel, i)) * (W+9)'($signed({1'b0, tap_d[i]}));
      end
      case (hps_pkg::hps_pf_e'(i_sel))
        hps_pkg::PF_121:   shf = acc >>> hps_pkg::SH_121;
        hps_pkg::PF_WIDE:  shf = acc >>> hps_pkg::SH_WIDE;
        hps_pkg::PF_12221: shf = acc >>> hps_pkg::SH_12221;
        default:           shf = acc;
      endcase
      if (shf < 0) begin
        filt_d = '0;
      end else if (shf > (W+9)'((1 << W) - 1)) begin
        filt_d = '1;
      end else begin
        filt_d = shf[W-1:0];
      end
      raw_d = tap_d[3];
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NT; i++) begin
        tap_q[i] <= '0;
      end
      filt_q <= '0;
      raw_q  <= '0;
      v_q    <= 1'b0;
      s_q    <= 1'b0;
      e_q    <= 1'b0;
    end else begin
      tap_q  <= tap_d;
      filt_q <= filt_d;
      raw_q  <= raw_d;
      v_q    <= i_valid;
      s_q    <= i_valid && i_sol;
      e_q    <= i_valid && i_eol;
    end
  end
  assign o_valid = v_q;
  assign o_sol   = s_q;
  assign o_eol   = e_q;
  assign o_filt  = filt_q;
  assign o_raw   = raw_q;
endmodule : hps_prefilter
`default_nettype wire

// ==== hdl/hps_prescaler.sv ====
`timescale 1ns/1ns
`default_nettype none
module hps_prescaler #(
  parameter int W     = 8,
  parameter int DEPTH = hps_pkg::FIFO_DEPTH
) (
  input  wire logic          I_CLK_SYS,
  input  wire logic          I_RESET_N,
  input  wire logic          I_REG_WR,
  input  wire logic [7:0]    I_REG_ADDR,
  input  wire logic [7:0]    I_REG_WDATA,
  output logic [7:0]         O_REG_RDATA,
  input  wire logic          I_PIX_VALID,
  input  wire logic          I_PIX_SOL,
  input  wire logic          I_PIX_EOL,
  input  wire logic [W-1:0]  I_PIX_Y,
  input  wire logic [W-1:0]  I_PIX_C,
  output logic               O_PIX_READY,
  input  wire logic [12:0]   I_FINE_PHASE_INC,
  output logic [12:0]        O_FINE_PHASE_INC,
  output logic [6:0]         O_DC_GAIN,
  output logic               O_OUT_VALID,
  input  wire logic          I_OUT_READY,
  output logic [W-1:0]       O_OUT_Y,
  output logic [W-1:0]       O_OUT_C,
  output logic               O_OUT_EOL
);
  localparam int AW = 16;
  localparam int FW = 2*W + 1;
  localparam int CW = $clog2(DEPTH+1);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0]    ratio_q, ratio_d, accl_q, accl_d, pfgw_q, pfgw_d;
  logic [7:0]    rdata_q, rdata_d;
  logic [12:0]   inc_q, inc_d;
  logic [6:0]    gain_q, gain_d;
  logic          rdy_q, rdy_d;
  logic [5:0]    psc, acl;
  logic [2:0]    dcg;
  logic          dbl;
  logic          fv, fsol, feol;
  logic [W-1:0]  fy, fc, ry, rc;
  logic [5:0]    phase_q, phase_d;
  logic          sel_q, sel_d;
  logic          first_q, first_d;
  hps_pkg::hps_line_e line_q, line_d;
  logic [AW-1:0] accy_q [2];
  logic [AW-1:0] accy_d [2];
  logic [AW-1:0] accc_q [2];
  logic [AW-1:0] accc_d [2];
  logic [5:0]    cnt_q [2];
  logic [5:0]    cnt_d [2];
  logic          act_q [2];
  logic          act_d [2];
  logic          start, st, live, done;
  logic [5:0]    pos;
  logic [AW-1:0] sy, sc, dy, dc;
  logic          emv_q, emv_d, eme_q, eme_d;
  logic [W-1:0]  emy_q, emy_d, emc_q, emc_d;
  logic          f_rdy;
  logic [CW-1:0] f_free;
  logic [FW-1:0] f_out;
  logic          f_ov;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [AW-1:0] wpix(input logic [W-1:0] p, input logic two);
    return two ? AW'({p, 1'b0}) : AW'(p);
  endfunction : wpix
  function automatic logic [W-1:0] norm(input logic [AW-1:0] v, input logic [2:0] n);
    logic [AW-1:0] s;
    s = v >> n;
    return (s > AW'((1 << W) - 1)) ? '1 : s[W-1:0];
  endfunction : norm
  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_comb begin
    ratio_d = ratio_q;
    accl_d  = accl_q;
    pfgw_d  = pfgw_q;
    if (I_REG_WR) begin
      case (I_REG_ADDR)
        hps_pkg::ADDR_PRESCALE: ratio_d = I_REG_WDATA;
        hps_pkg::ADDR_ACCUM:    accl_d  = I_REG_WDATA;
        hps_pkg::ADDR_PFGW:     pfgw_d  = I_REG_WDATA;
        default:                ratio_d = ratio_q;
      endcase
    end
    case (I_REG_ADDR)
      hps_pkg::ADDR_PRESCALE: rdata_d = ratio_q;
      hps_pkg::ADDR_ACCUM:    rdata_d = accl_q;
      hps_pkg::ADDR_PFGW:     rdata_d = pfgw_q;
      default:                rdata_d = 8'h00;
    endcase
  end
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ratio_q <= hps_pkg::RST_PRESCALE;
      accl_q  <= hps_pkg::RST_ACCUM;
      pfgw_q  <= hps_pkg::RST_PFGW;
      rdata_q <= 8'h00;
    end else begin
      ratio_q <= ratio_d;
      accl_q  <= accl_d;
      pfgw_q  <= pfgw_d;
      rdata_q <= rdata_d;
    end
  end
  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  always_comb begin
    psc = ratio_q[hps_pkg::RATIO_LSB +: hps_pkg::RATIO_W];
    if (psc == 6'h00) begin
      psc = 6'h01;
    end
    acl = accl_q[hps_pkg::ACL_LSB +: hps_pkg::ACL_W];
    dcg = pfgw_q[hps_pkg::DCG_LSB +: hps_pkg::DCG_W];
    dbl = pfgw_q[hps_pkg::WEIGHT_BIT];
    gain_d = dbl ? {acl, 1'b0} : 7'({1'b0, acl} + 7'h01);
    inc_d = I_FINE_PHASE_INC;
    if (I_FINE_PHASE_INC < hps_pkg::PHASE_INC_MIN) begin
      inc_d = hps_pkg::PHASE_INC_MIN;
    end
    rdy_d = f_free > CW'(hps_pkg::READY_MARGIN);
  end
  // ---------------------------------------------------------------
  // prefilters
  // ---------------------------------------------------------------
  hps_prefilter #(
    .W    (W),
    .LUMA (1'b1)
  ) u_pf_y (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RESET_N),
    .i_valid (I_PIX_VALID && rdy_q),
    .i_sol   (I_PIX_SOL),
    .i_eol   (I_PIX_EOL),
    .i_sel   (pfgw_q[hps_pkg::PFY_LSB +: hps_pkg::PF_W]),
    .i_data  (I_PIX_Y),
    .o_valid (fv),
    .o_sol   (fsol),
    .o_eol   (feol),
    .o_filt  (fy),
    .o_raw   (ry)
  );
  hps_prefilter #(
    .W    (W),
    .LUMA (1'b0)
  ) u_pf_c (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RESET_N),
    .i_valid (I_PIX_VALID && rdy_q),
    .i_sol   (I_PIX_SOL),
    .i_eol   (I_PIX_EOL),
    .i_sel   (pfgw_q[hps_pkg::PFUV_LSB +: hps_pkg::PF_W]),
    .i_data  (I_PIX_C),
    .o_valid (),
    .o_sol   (),
    .o_eol   (),
    .o_filt  (fc),
    .o_raw   (rc)
  );
  // ---------------------------------------------------------------
  // integer prescaler
  // ---------------------------------------------------------------
  always_comb begin
    phase_d = phase_q;
    sel_d   = sel_q;
    first_d = first_q;
    line_d  = line_q;
    accy_d  = accy_q;
    accc_d  = accc_q;
    cnt_d   = cnt_q;
    act_d   = act_q;
    emv_d   = 1'b0;
    emy_d   = emy_q;
    emc_d   = emc_q;
    eme_d   = eme_q;
    done    = 1'b0;
    dy      = '0;
    dc      = '0;
    st      = 1'b0;
    live    = 1'b0;
    pos     = '0;
    sy      = '0;
    sc      = '0;
    start   = fv && (fsol || phase_q == 6'h00) && (fsol || line_q == hps_pkg::LN_ACTIVE);
    if (fv && (fsol || line_q == hps_pkg::LN_ACTIVE)) begin
      if (fsol) begin
        first_d = 1'b1;
        line_d  = hps_pkg::LN_ACTIVE;
      end
      phase_d = (psc == 6'h01) ? 6'h00 : (fsol ? 6'h01 :
                ((phase_q + 6'h01 == psc) ? 6'h00 : phase_q + 6'h01));
      if (start) begin
        sel_d = ~sel_q;
      end
      for (int k = 0; k < 2; k++) begin
        st   = start && (1'(k) == ~sel_q);
        live = st || (act_q[k] && !fsol);
        pos  = st ? 6'h00 : cnt_q[k] + 6'h01;
        if (live) begin
          sy = (st ? '0 : accy_q[k]) + wpix(fy, dbl && pos != 6'h00 && pos != acl);
          sc = (st ? '0 : accc_q[k]) + wpix(fc, dbl && pos != 6'h00 && pos != acl);
          if (pos == acl) begin
            act_d[k] = 1'b0;
            done     = 1'b1;
            dy       = sy;
            dc       = sc;
          end else begin
            act_d[k]  = 1'b1;
            cnt_d[k]  = pos;
            accy_d[k] = sy;
            accc_d[k] = sc;
          end
        end else if (fsol) begin
          act_d[k] = 1'b0;
        end
      end
      if (feol) begin
        emv_d   = 1'b1;
        emy_d   = ry;
        emc_d   = rc;
        eme_d   = 1'b1;
        line_d  = hps_pkg::LN_IDLE;
        act_d   = '{1'b0, 1'b0};
      end else if (done) begin
        emv_d   = 1'b1;
        eme_d   = 1'b0;
        first_d = 1'b0;
        emy_d   = (first_q || fsol) ? ry : norm(dy, dcg);
        emc_d   = (first_q || fsol) ? rc : norm(dc, dcg);
      end
    end
  end
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      phase_q <= 6'h00;
      sel_q   <= 1'b0;
      first_q <= 1'b0;
      line_q  <= hps_pkg::LN_IDLE;
      for (int k = 0; k < 2; k++) begin
        accy_q[k] <= '0;
        accc_q[k] <= '0;
        cnt_q[k]  <= 6'h00;
        act_q[k]  <= 1'b0;
      end
      emv_q   <= 1'b0;
      emy_q   <= '0;
      emc_q   <= '0;
      eme_q   <= 1'b0;
      inc_q   <= hps_pkg::PHASE_INC_MIN;
      gain_q  <= 7'h00;
      rdy_q   <= 1'b0;
    end else begin
      phase_q <= phase_d;
      sel_q   <= sel_d;
      first_q <= first_d;
      line_q  <= line_d;
      accy_q  <= accy_d;
      accc_q  <= accc_d;
      cnt_q   <= cnt_d;
      act_q   <= act_d;
      emv_q   <= emv_d;
      emy_q   <= emy_d;
      emc_q   <= emc_d;
      eme_q   <= eme_d;
      inc_q   <= inc_d;
      gain_q  <= gain_d;
      rdy_q   <= rdy_d;
    end
  end
  // ---------------------------------------------------------------
  // output buffer
  // ---------------------------------------------------------------
  hps_fifo #(
    .W     (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RESET_N),
    .i_valid (emv_q && f_rdy),
    .o_ready (f_rdy),
    .i_data  ({eme_q, emc_q, emy_q}),
    .o_valid (f_ov),
    .i_ready (I_OUT_READY),
    .o_data  (f_out),
    .o_free  (f_free)
  );
  assign O_REG_RDATA      = rdata_q;
  assign O_PIX_READY      = rdy_q;
  assign O_FINE_PHASE_INC = inc_q;
  assign O_DC_GAIN        = gain_q;
  assign O_OUT_VALID      = f_ov;
  assign O_OUT_Y          = f_out[W-1:0];
  assign O_OUT_C          = f_out[2*W-1:W];
  assign O_OUT_EOL        = f_out[2*W];
endmodule : hps_prescaler
`default_nettype wire

// ==== sim/hps_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module hps_checker #(
  parameter int W = 8
) (
  input wire logic         I_CLK_SYS,
  input wire logic         I_RESET_N,
  input wire logic         I_REG_WR,
  input wire logic [7:0]   I_REG_ADDR,
  input wire logic [7:0]   I_REG_WDATA,
  input wire logic [7:0]   O_REG_RDATA,
  input wire logic         I_PIX_VALID,
  input wire logic         I_PIX_SOL,
  input wire logic         O_PIX_READY,
  input wire logic [12:0]  I_FINE_PHASE_INC,
  input wire logic [12:0]  O_FINE_PHASE_INC,
  input wire logic [6:0]   O_DC_GAIN,
  input wire logic         O_OUT_VALID,
  input wire logic         I_OUT_READY,
  input wire logic [W-1:0] O_OUT_Y,
  input wire logic [W-1:0] O_OUT_C,
  input wire logic         O_OUT_EOL
);
  // ---------------------------------------------------------------
  // shadow of length and weight fields
  // ---------------------------------------------------------------
  logic [5:0] acl_q;
  logic       wt_q;
  logic [6:0] gain;
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      acl_q <= 6'h00;
      wt_q  <= 1'b0;
    end else if (I_REG_WR && I_REG_ADDR == 8'ha1) begin
      acl_q <= I_REG_WDATA[5:0];
    end else if (I_REG_WR && I_REG_ADDR == 8'ha2) begin
      wt_q <= I_REG_WDATA[3];
    end
  end
  assign gain = wt_q ? {acl_q, 1'b0} : 7'(acl_q) + 7'h01;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  rd_unmapped_a: assert property (
    !(I_REG_ADDR inside {8'ha0, 8'ha1, 8'ha2}) |=> O_REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  wr_readback_a: assert property (
    (I_REG_WR && I_REG_ADDR inside {8'ha0, 8'ha1, 8'ha2} ##1 !I_REG_WR && $stable(I_REG_ADDR))
    |=> O_REG_RDATA == $past(I_REG_WDATA, 2))
    else $error("register readback wrong");
  phase_clamp_a: assert property (
    $past(I_RESET_N, 3) |-> O_FINE_PHASE_INC == (($past(I_FINE_PHASE_INC) < 13'h012c) ?
    13'h012c : $past(I_FINE_PHASE_INC)))
    else $error("phase step not clamped");
  dc_gain_a: assert property ($past(I_RESET_N, 3) |-> O_DC_GAIN == $past(gain))
    else $error("dc gain wrong");
  out_hold_a: assert property (
    O_OUT_VALID && !I_OUT_READY |=> O_OUT_VALID && $stable({O_OUT_Y, O_OUT_C, O_OUT_EOL}))
    else $error("output dropped while stalled");
  pix_latency_a: assert property (
    I_PIX_VALID && O_PIX_READY && I_PIX_SOL |-> ##[3:80] O_OUT_VALID)
    else $error("no output after line start");
  reset_quiet_a: assert property ($rose(I_RESET_N) |-> (!O_OUT_VALID) [*3])
    else $error("output valid after reset");
  ready_rise_a: assert property ($rose(I_RESET_N) |-> ##[1:3] O_PIX_READY)
    else $error("input ready late after reset");
endmodule : hps_checker
bind hps_prescaler hps_checker #(.W(W)) u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_REG_WR(I_REG_WR),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
  .I_PIX_VALID(I_PIX_VALID), .I_PIX_SOL(I_PIX_SOL), .O_PIX_READY(O_PIX_READY),
  .I_FINE_PHASE_INC(I_FINE_PHASE_INC), .O_FINE_PHASE_INC(O_FINE_PHASE_INC),
  .O_DC_GAIN(O_DC_GAIN), .O_OUT_VALID(O_OUT_VALID), .I_OUT_READY(I_OUT_READY),
  .O_OUT_Y(O_OUT_Y), .O_OUT_C(O_OUT_C), .O_OUT_EOL(O_OUT_EOL));
`default_nettype wire

// ==== sim/hps_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module hps_far_model (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic [7:0] i_len,
  input  wire logic [7:0] i_y,
  input  wire logic [7:0] i_c,
  input  wire logic       i_pix_ready,
  output logic            o_valid,
  output logic            o_sol,
  output logic            o_eol,
  output logic [7:0]      o_y,
  output logic [7:0]      o_c,
  output logic            o_out_ready
);
  // ---------------------------------------------------------------
  // line source and stalling sink
  // ---------------------------------------------------------------
  int   pos;
  int   len;
  logic go;
  initial begin
    {o_valid, o_sol, o_eol, o_y, o_c, o_out_ready} = '0;
    pos = 0;
    len = 0;
  end
  always @(posedge i_clk) begin
    o_out_ready <= ($urandom % 4) != 0;
    if (o_valid && i_pix_ready) pos = pos + 1;
    if (i_start) begin
      pos = 0;
      len = i_len;
    end
    // a pending pixel is held until taken
    if (!(o_valid && !i_pix_ready)) begin
      go = (pos < len) && (($urandom % 4) != 0);
      o_valid <= go;
      o_sol <= go && pos == 0;
      o_eol <= go && pos == len - 1;
      o_y <= go ? i_y : ~o_y;
      o_c <= go ? i_c : ~o_c;
    end
  end
endmodule : hps_far_model
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk, rst_n, reg_wr, start, first, w;
  logic        pix_valid, pix_sol, pix_eol, pix_ready;
  logic        out_valid, out_ready, out_eol;
  logic [7:0]  reg_addr, reg_wdata, rdata, pix_y, pix_c, out_y, out_c;
  logic [7:0]  len, vy, vc;
  logic [12:0] phase, phase_o, pv;
  logic [12:0] ph [5];
  logic [6:0]  dc_gain, gain;
  logic [5:0]  p, acl;
  logic [2:0]  dcg;
  int          failures, n_compared, cyc, lines_done, n_out, t, i;
  hps_prescaler #(.W(8)) dut (
    .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_REG_WR(reg_wr), .I_REG_ADDR(reg_addr),
    .I_REG_WDATA(reg_wdata), .O_REG_RDATA(rdata), .I_PIX_VALID(pix_valid),
    .I_PIX_SOL(pix_sol), .I_PIX_EOL(pix_eol), .I_PIX_Y(pix_y), .I_PIX_C(pix_c),
    .O_PIX_READY(pix_ready), .I_FINE_PHASE_INC(phase), .O_FINE_PHASE_INC(phase_o),
    .O_DC_GAIN(dc_gain), .O_OUT_VALID(out_valid), .I_OUT_READY(out_ready),
    .O_OUT_Y(out_y), .O_OUT_C(out_c), .O_OUT_EOL(out_eol));
  hps_far_model far (
    .i_clk(clk), .i_start(start), .i_len(len), .i_y(vy), .i_c(vc),
    .i_pix_ready(pix_ready), .o_valid(pix_valid), .o_sol(pix_sol), .o_eol(pix_eol),
    .o_y(pix_y), .o_c(pix_c), .o_out_ready(out_ready));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 check(16'(rdata), 16'(e));
  endtask : rd_chk
  function automatic logic [6:0] gain_of(input logic wb, input logic [5:0] a);
    return wb ? {a, 1'b0} : 7'(a) + 7'h01;
  endfunction : gain_of
  function automatic logic [7:0] inner(input logic [7:0] v);
    logic [15:0] s;
    s = (16'(v) * 16'(gain)) >> dcg;
    return (s > 16'h00ff) ? 8'hff : s[7:0];
  endfunction : inner
  // ---------------------------------------------------------------
  // clock, monitor and timeout
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (rst_n && out_valid && out_ready) begin
      check(16'(out_y), 16'((first || out_eol) ? vy : inner(vy)));
      check(16'(out_c), 16'((first || out_eol) ? vc : inner(vc)));
      first = out_eol;
      n_out++;
      if (out_eol) begin
        check(16'(n_out), 16'((len - 2 - acl) / p + 2));
        n_out = 0;
        lines_done++;
      end
    end
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(66));
    {rst_n, reg_wr, start, reg_addr, reg_wdata, len} = '0;
    phase = 13'h012c;
    first = 1'b1;
    ph = '{13'h0000, 13'h012b, 13'h012c, 13'h012d, 13'h1fff};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(8'ha0, 8'h01);
    rd_chk(8'ha1, 8'h00);
    rd_chk(8'ha2, 8'h00);
    wr(8'ha3, 8'h5a);
    rd_chk(8'ha3, 8'h00);
    for (i = 0; i < 8; i++) begin
      pv = (i < 5) ? ph[i] : 13'($urandom % 8192);
      @(posedge clk);
      phase <= pv;
      repeat (2) @(posedge clk);
      #1 check(16'(phase_o), 16'((pv < 13'h012c) ? 13'h012c : pv));
    end
    for (t = 0; t < 16; t++) begin
      p = 6'(1 + $urandom % 4);
      acl = 6'($urandom % (2 * p));
      w = (acl != 6'h00) && ($urandom % 2 == 1);
      if (t < 2) begin
        p = 6'h01;
        acl = 6'(t);
        w = 1'b0;
      end
      gain = gain_of(w, acl);
      dcg = 3'h0;
      while (t != 1 && (7'h01 << dcg) < gain) dcg++;
      if (t > 1) dcg = dcg + 3'($urandom % (8 - dcg));
      vy = (t == 1) ? 8'hff : 8'($urandom);
      vc = 8'($urandom);
      wr(8'ha0, {2'b00, p});
      wr(8'ha1, {2'b00, acl});
      wr(8'ha2, {2'(t >> 2), 2'(t), w, dcg});
      rd_chk(8'ha2, {2'(t >> 2), 2'(t), w, dcg});
      rd_chk(8'ha1, {2'b00, acl});
      check(16'(dc_gain), 16'(gain));
      @(posedge clk);
      len <= 8'(10 + $urandom % 20);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      while (lines_done <= t) @(posedge clk);
    end
    results();
  end
endmodule : tb_top
`default_nettype wire
